//--- pkg/modbus_pim_pkg.sv
// package: constants and carrier types for the process image map
package modbus_pim_pkg;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INPUT = 8'h04;
    localparam logic [7:0] FC_WR_SINGLE = 8'h06;
    localparam logic [7:0] FC_WR_MULTI = 8'h10;
    localparam logic [7:0] FC_RD_WR = 8'h17;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FAIL = 8'h04;
    localparam logic [15:0] IDX_RX_MAP = 16'h3502;
    localparam logic [15:0] IDX_TX_MAP = 16'h3602;
    localparam logic [15:0] IDX_DUMMY_LO = 16'h0002;
    localparam logic [15:0] IDX_DUMMY_HI = 16'h0007;
    localparam logic [15:0] BASE_RX = 16'h1770;
    localparam logic [15:0] BASE_TX = 16'h1388;
    localparam logic [15:0] BASE_UOUT = 16'h07d0;
    localparam logic [15:0] BASE_UIN = 16'h0bb8;
    localparam logic [15:0] USER_WORDS = 16'h0040;
    localparam logic [15:0] MAX_RD_QTY = 16'h007d;
    localparam logic [15:0] MAX_WR_QTY = 16'h007b;
    localparam logic [7:0] LEN_8 = 8'h08;
    localparam logic [7:0] LEN_16 = 8'h10;
    localparam logic [7:0] LEN_32 = 8'h20;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam int MAP_ENTRIES = 16;
    localparam int USER_VALUES = 32;
    localparam int IMG_BITS = 512;
    localparam int ENT_IDX_LSB = 16;
    localparam int ENT_SUB_LSB = 8;
    localparam int ENT_LEN_LSB = 0;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_WRDATA = 6'h02,
        S_RXWALK = 6'h04,
        S_TXWALK = 6'h08,
        S_RDDATA = 6'h10,
        S_DONE = 6'h20
    } state_type;

    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_TX = 3'h1,
        REG_RX = 3'h2,
        REG_UOUT = 3'h3,
        REG_UIN = 3'h4
    } region_type;

    typedef struct packed {
        logic valid;
        logic [7:0] fc;
        logic [15:0] rdAddr;
        logic [15:0] rdQty;
        logic [15:0] wrAddr;
        logic [15:0] wrQty;
    } req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } map_wr_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [7:0] bits;
        logic [31:0] data;
    } od_req_type;

    typedef struct packed {
        logic done;
        logic fail;
        logic [31:0] data;
    } od_rsp_type;
endpackage : modbus_pim_pkg

//--- rtl/modbus_process_image_map.sv
// rtl: modbus register access to process images and user arrays
`timescale 1ns/100ps
`default_nettype none
module modbus_process_image_map
    import modbus_pim_pkg::*;
#(
    parameter int ENTRIES = MAP_ENTRIES // mapping slots per table
) (
    input wire logic sys_clk, // 125 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire req_type req, // decoded modbus request
    output logic reqReady, // request taken while high
    input wire logic [15:0] wrWord, // register value from master
    input wire logic wrValid, // wrWord present
    output logic wrReady, // wrWord taken while high
    output logic [15:0] rdWord, // register value to master
    output logic rdValid, // rdWord present
    input wire logic rdReady, // rdWord taken
    output logic done, // request finished, pulse
    output logic [7:0] excCode, // exception code, 00 on success
    input wire map_wr_type mapWr, // mapping table write
    output logic mapAck, // mapping write answered, pulse
    output logic [7:0] mapExc, // mapping write exception
    output od_req_type odReq, // object dictionary access
    input wire od_rsp_type odRsp, // object dictionary answer
    input wire logic [USER_VALUES-1:0][31:0] userOut, // program outputs
    output logic [USER_VALUES-1:0][31:0] userIn // program inputs
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    state_type state, next_state;
    req_type cur;
    region_type rdReg, wrReg, rdRegion, wrRegion;
    logic [7:0] mapCnt [2];
    logic [31:0] mapEnt [2][ENTRIES];
    logic [IMG_BITS+31:0] txImg, rxImg;
    logic [15:0] rdPtr, wrPtr, rdLeft, wrLeft, hold;
    logic [4:0] ent;
    logic [9:0] bitOff, txBits, rxBits;
    logic pend, rdPrimed;

    function automatic logic [9:0] bitsOf(input logic tbl);
        logic [9:0] s;
        s = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (i < int'(mapCnt[tbl])) begin
                s = s + 10'(mapEnt[tbl][i][ENT_LEN_LSB +: 8]);
            end
        end
        return s;
    endfunction : bitsOf

    function automatic logic fits(input logic [15:0] a,
        input logic [15:0] q, input logic [15:0] b, input logic [15:0] n);
        return (a >= b) && ((17'(a) + 17'(q)) <= (17'(b) + 17'(n)));
    endfunction : fits

    function automatic logic [31:0] maskTo(input logic [31:0] v,
        input logic [7:0] n);
        if (n == LEN_8) begin
            return {24'h000000, v[7:0]};
        end else if (n == LEN_16) begin
            return {16'h0000, v[15:0]};
        end
        return v;
    endfunction : maskTo

    // ------------------------------------------------------------
    // request checks
    // ------------------------------------------------------------
    logic [15:0] txWords, rxWords, wrQtyEff, rdOffU, wrOffU;
    logic fcKnown, hasRd, hasWr, curHasRd, qtyBad, userFcBad, alignBad;
    logic addrBad, accept, wrBeat, rdBeat, walking, walkTx, walkEnd;
    logic eDummy, odFail;
    logic [7:0] reqExc, eLen;
    logic [31:0] ent32;
    state_type rdStart;

    // table totals read the map arrays inside the function
    always_comb begin
        txBits = bitsOf(1'b1);
        rxBits = bitsOf(1'b0);
    end
    assign txWords = 16'((txBits + 10'h00f) >> 4);
    assign rxWords = 16'((rxBits + 10'h00f) >> 4);
    assign fcKnown = (req.fc == FC_RD_HOLD) || (req.fc == FC_RD_INPUT)
        || (req.fc == FC_WR_SINGLE) || (req.fc == FC_WR_MULTI)
        || (req.fc == FC_RD_WR);
    assign hasRd = (req.fc == FC_RD_HOLD) || (req.fc == FC_RD_INPUT)
        || (req.fc == FC_RD_WR);
    assign hasWr = (req.fc == FC_WR_SINGLE) || (req.fc == FC_WR_MULTI)
        || (req.fc == FC_RD_WR);
    assign wrQtyEff = (req.fc == FC_WR_SINGLE) ? 16'h0001 : req.wrQty;
    assign qtyBad = (hasRd && (req.rdQty == 16'h0000
        || req.rdQty > MAX_RD_QTY)) || (hasWr && (wrQtyEff == 16'h0000
        || wrQtyEff > MAX_WR_QTY));
    assign rdRegion = !hasRd ? REG_NONE
        : fits(req.rdAddr, req.rdQty, BASE_TX, txWords) ? REG_TX
        : fits(req.rdAddr, req.rdQty, BASE_UOUT, USER_WORDS) ? REG_UOUT
        : REG_NONE;
    assign wrRegion = !hasWr ? REG_NONE
        : fits(req.wrAddr, wrQtyEff, BASE_RX, rxWords) ? REG_RX
        : fits(req.wrAddr, wrQtyEff, BASE_UIN, USER_WORDS) ? REG_UIN
        : REG_NONE;
    assign rdOffU = req.rdAddr - BASE_UOUT;
    assign wrOffU = req.wrAddr - BASE_UIN;
    assign userFcBad = (req.fc == FC_WR_SINGLE)
        && (req.wrAddr >= BASE_UIN)
        && (req.wrAddr < BASE_UIN + USER_WORDS);
    assign alignBad = (rdRegion == REG_UOUT && (rdOffU[0] || req.rdQty[0]))
        || (wrRegion == REG_UIN && (wrOffU[0] || wrQtyEff[0]));
    assign addrBad = (hasRd && rdRegion == REG_NONE)
        || (hasWr && wrRegion == REG_NONE) || alignBad;
    assign reqExc = (!fcKnown || userFcBad) ? EXC_FUNC
        : qtyBad ? EXC_VALUE : addrBad ? EXC_ADDR : EXC_NONE;

    // ------------------------------------------------------------
    // handshakes and walk decode
    // ------------------------------------------------------------
    assign reqReady = (state == S_IDLE);
    assign accept = req.valid && reqReady;
    assign wrReady = (state == S_WRDATA);
    assign wrBeat = wrValid && wrReady;
    assign rdValid = (state == S_RDDATA) && rdPrimed;
    assign rdBeat = rdValid && rdReady;
    assign done = (state == S_DONE);
    assign curHasRd = (cur.fc == FC_RD_HOLD) || (cur.fc == FC_RD_INPUT)
        || (cur.fc == FC_RD_WR);
    assign rdStart = !curHasRd ? S_DONE
        : (rdReg == REG_TX) ? S_TXWALK : S_RDDATA;
    assign walkTx = (state == S_TXWALK);
    assign walking = walkTx || (state == S_RXWALK);
    assign walkEnd = {3'h0, ent} >= mapCnt[walkTx];
    assign ent32 = mapEnt[walkTx][ent[3:0]];
    assign eLen = ent32[ENT_LEN_LSB +: 8];
    assign eDummy = (ent32[ENT_IDX_LSB +: 16] >= IDX_DUMMY_LO)
        && (ent32[ENT_IDX_LSB +: 16] <= IDX_DUMMY_HI);
    assign odFail = pend && odRsp.done && odRsp.fail;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (accept && reqExc != EXC_NONE) begin
                    next_state = S_DONE;
                end else if (accept && hasWr) begin
                    next_state = S_WRDATA;
                end else if (accept) begin
                    next_state = (rdRegion == REG_TX) ? S_TXWALK : S_RDDATA;
                end
            end
            S_WRDATA: begin
                if (wrBeat && wrLeft == 16'h0001) begin
                    next_state = (wrReg == REG_RX) ? S_RXWALK : rdStart;
                end
            end
            S_RXWALK, S_TXWALK: begin
                if (odFail) begin
                    next_state = S_DONE;
                end else if (!pend && walkEnd) begin
                    next_state = walkTx ? S_RDDATA : rdStart;
                end
            end
            S_RDDATA: begin
                if (rdBeat && rdLeft == 16'h0001) begin
                    next_state = S_DONE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        state <= sys_rst ? S_IDLE : next_state;
        rdPrimed <= !sys_rst && (state == S_RDDATA);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur <= '0;
            rdReg <= REG_NONE;
            wrReg <= REG_NONE;
            excCode <= EXC_NONE;
        end else if (accept) begin
            cur <= req;
            rdReg <= rdRegion;
            wrReg <= wrRegion;
            excCode <= reqExc;
        end else if (odFail) begin
            excCode <= EXC_FAIL;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdPtr <= '0;
            wrPtr <= '0;
            rdLeft <= '0;
            wrLeft <= '0;
        end else if (accept) begin
            rdPtr <= req.rdAddr;
            wrPtr <= req.wrAddr;
            rdLeft <= req.rdQty;
            wrLeft <= wrQtyEff;
        end else begin
            rdPtr <= rdPtr + 16'(rdBeat);
            rdLeft <= rdLeft - 16'(rdBeat);
            wrPtr <= wrPtr + 16'(wrBeat);
            wrLeft <= wrLeft - 16'(wrBeat);
        end
    end

    // ------------------------------------------------------------
    // mapping walk and object access
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !walking) begin
            ent <= '0;
            bitOff <= '0;
            pend <= 1'b0;
            odReq <= '0;
        end else if (pend && odRsp.done) begin
            pend <= 1'b0;
            odReq.valid <= 1'b0;
            ent <= ent + 5'h01;
            bitOff <= bitOff + 10'(eLen);
        end else if (!pend && !walkEnd && eDummy) begin
            ent <= ent + 5'h01;
            bitOff <= bitOff + 10'(eLen);
        end else if (!pend && !walkEnd) begin
            pend <= 1'b1;
            odReq <= '{valid: 1'b1, write: !walkTx,
                index: ent32[ENT_IDX_LSB +: 16], sub: ent32[ENT_SUB_LSB +: 8],
                bits: eLen, data: maskTo(rxImg[bitOff +: 32], eLen)};
        end
    end

    // ------------------------------------------------------------
    // images and user arrays
    // ------------------------------------------------------------
    logic [15:0] wrOff, rdNext, rdOff;
    assign wrOff = wrPtr - ((wrReg == REG_RX) ? BASE_RX : BASE_UIN);
    assign rdNext = rdPtr + 16'(rdBeat);
    assign rdOff = rdNext - ((rdReg == REG_TX) ? BASE_TX : BASE_UOUT);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || accept) begin
            txImg <= '0;
        end else if (walkTx && pend && odRsp.done && !odRsp.fail) begin
            txImg[bitOff +: 32] <= maskTo(odRsp.data, eLen);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxImg <= '0;
            hold <= '0;
            userIn <= '0;
        end else if (wrBeat && wrReg == REG_RX) begin
            rxImg[{wrOff[5:0], 4'h0} +: 16] <= wrWord;
        end else if (wrBeat && !wrOff[0]) begin
            hold <= wrWord;
        end else if (wrBeat) begin
            userIn[wrOff[5:1]] <= {hold, wrWord};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdWord <= '0;
        end else if (rdReg == REG_TX) begin
            rdWord <= txImg[{rdOff[5:0], 4'h0} +: 16];
        end else begin
            rdWord <= rdOff[0] ? userOut[rdOff[5:1]][15:0]
                : userOut[rdOff[5:1]][31:16];
        end
    end

    // ------------------------------------------------------------
    // mapping table writes
    // ------------------------------------------------------------
    logic mapTbl, mapIdxOk, mapLenOk;
    logic [7:0] next_mapExc, mapData8;
    assign mapTbl = (mapWr.index == IDX_TX_MAP);
    assign mapIdxOk = (mapWr.index == IDX_RX_MAP) || mapTbl;
    assign mapData8 = mapWr.data[7:0];
    assign mapLenOk = (mapWr.data[ENT_LEN_LSB +: 8] == LEN_8)
        || (mapWr.data[ENT_LEN_LSB +: 8] == LEN_16)
        || (mapWr.data[ENT_LEN_LSB +: 8] == LEN_32);
    assign next_mapExc = !mapIdxOk ? EXC_ADDR
        : (mapWr.sub == 8'h00) ? ((mapWr.data > 32'(ENTRIES))
            ? EXC_VALUE : EXC_NONE)
        : (mapWr.sub > 8'(ENTRIES)) ? EXC_ADDR
        : (mapCnt[mapTbl] != CNT_RESET) ? EXC_VALUE
        : !mapLenOk ? EXC_VALUE : EXC_NONE;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mapCnt <= '{default: CNT_RESET};
            mapAck <= 1'b0;
            mapExc <= EXC_NONE;
        end else begin
            mapAck <= mapWr.valid;
            mapExc <= mapWr.valid ? next_mapExc : mapExc;
            if (mapWr.valid && next_mapExc == EXC_NONE
                && mapWr.sub == 8'h00) begin
                mapCnt[mapTbl] <= mapData8;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mapWr.valid && next_mapExc == EXC_NONE && mapWr.sub != 8'h00) begin
            mapEnt[mapTbl][4'(mapWr.sub - 8'h01)] <= mapWr.data;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_badFunc;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && !fcKnown |=> done && excCode == EXC_FUNC;
    endproperty
    a_badFunc: assert property (p_badFunc)
        else $error("unknown function not refused with 01");

    property p_dummy;
        @(posedge sys_clk) disable iff (sys_rst)
        walking && !pend && !walkEnd && eDummy
        |=> !odReq.valid && bitOff == $past(bitOff) + 10'($past(eLen));
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy entry accessed the dictionary");

    property p_pack;
        @(posedge sys_clk) disable iff (sys_rst)
        walkTx && pend && odRsp.done && !odRsp.fail
        |=> bitOff == $past(bitOff) + 10'($past(eLen)) && !pend;
    endproperty
    a_pack: assert property (p_pack)
        else $error("image offset not advanced by entry length");

    property p_rxBase;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.fc == FC_WR_SINGLE && req.wrAddr == BASE_RX
        && rxWords != 16'h0000
        |=> state == S_WRDATA && wrReady && excCode == EXC_NONE;
    endproperty
    a_rxBase: assert property (p_rxBase)
        else $error("receive image base not accepted");

    property p_txBase;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.fc == FC_RD_HOLD && req.rdAddr == BASE_TX
        && req.rdQty == 16'h0001 && txWords != 16'h0000
        |=> state == S_TXWALK && excCode == EXC_NONE;
    endproperty
    a_txBase: assert property (p_txBase)
        else $error("transmit image base not accepted");

    property p_uoutRo;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.fc == FC_WR_MULTI && req.wrAddr == BASE_UOUT
        && !qtyBad |=> done && excCode == EXC_ADDR;
    endproperty
    a_uoutRo: assert property (p_uoutRo)
        else $error("write to user output array not refused");

    property p_uinWo;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.fc == FC_RD_HOLD && req.rdAddr == BASE_UIN
        && !qtyBad |=> done && excCode == EXC_ADDR;
    endproperty
    a_uinWo: assert property (p_uinWo)
        else $error("read of user input array not refused");

    property p_user06;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.fc == FC_WR_SINGLE && req.wrAddr == BASE_UIN
        |=> done && excCode == EXC_FUNC;
    endproperty
    a_user06: assert property (p_user06)
        else $error("single write to user array not refused");

    property p_misalign;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && fcKnown && !qtyBad && rdRegion == REG_UOUT && rdOffU[0]
        |=> excCode == EXC_ADDR;
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("misaligned user array read not refused");

    property p_mapLock;
        @(posedge sys_clk) disable iff (sys_rst)
        mapWr.valid && mapIdxOk && mapWr.sub == 8'h01
        && mapCnt[mapTbl] != CNT_RESET |=> mapAck && mapExc == EXC_VALUE;
    endproperty
    a_mapLock: assert property (p_mapLock)
        else $error("entry write to enabled table accepted");

    property p_mapEnable;
        @(posedge sys_clk) disable iff (sys_rst)
        mapWr.valid && next_mapExc == EXC_NONE && mapWr.sub == 8'h00
        |=> mapCnt[$past(mapTbl)] == $past(mapData8);
    endproperty
    a_mapEnable: assert property (p_mapEnable)
        else $error("count write did not take effect");
endmodule : modbus_process_image_map
`default_nettype wire

//--- bench/od_model.sv
// bench: object dictionary responder behind the process image map
`timescale 1ns/100ps
`default_nettype none
module od_model
    import modbus_pim_pkg::*;
#(
    parameter int LAT = 3, // answer comes LAT+1 cycles after odReq.valid
    parameter logic [15:0] FAIL_IDX = 16'hffff // index answered with failure
) (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire od_req_type odReq, // access from the block
    output var od_rsp_type odRsp, // answer to the block
    output logic [15:0] lastIdx, // index of last write
    output logic [31:0] lastData // data of last write
);
    int cnt;
    logic [31:0] held;
    // ---------------------------------------------
    // slow answer; data line shows garbage between
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt <= 0;
            odRsp <= '0;
            held <= '0;
            lastIdx <= '0;
            lastData <= '0;
        end else begin
            odRsp.done <= 1'b0;
            odRsp.fail <= 1'b0;
            odRsp.data <= ~held;
            if (odReq.valid && !odRsp.done) begin
                cnt <= cnt + 1;
                if (cnt == LAT) begin
                    cnt <= 0;
                    odRsp.done <= 1'b1;
                    odRsp.fail <= (odReq.index == FAIL_IDX);
                    odRsp.data <= {odReq.index, odReq.index};
                    held <= {odReq.index, odReq.index};
                    if (odReq.write) begin
                        lastIdx <= odReq.index;
                        lastData <= odReq.data;
                    end
                end
            end
        end
    end
endmodule : od_model
`default_nettype wire

//--- bench/modbus_process_image_map_bench.sv
// bench: self-checking test of the process image map
`timescale 1ns/100ps
`default_nettype none
module modbus_process_image_map_bench import modbus_pim_pkg::*;;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    req_type req = '0;
    logic [15:0] wrWord = '0;
    logic wrValid = 1'b0;
    logic rdReady = 1'b0;
    map_wr_type mapWr = '0;
    logic [USER_VALUES-1:0][31:0] userOut = '0;
    logic [USER_VALUES-1:0][31:0] userIn;
    logic reqReady, wrReady, rdValid, done, mapAck;
    logic [15:0] rdWord, lastIdx;
    logic [31:0] lastData;
    logic [7:0] excCode, mapExc;
    od_req_type odReq;
    od_rsp_type odRsp;
    int err_count = 0;
    int compares = 0;
    logic [15:0] wbuf [8];
    logic [15:0] ebuf [8];

    always #4 sys_clk = ~sys_clk;

    modbus_process_image_map DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .req(req), .reqReady(reqReady), .wrWord(wrWord), .wrValid(wrValid),
        .wrReady(wrReady), .rdWord(rdWord), .rdValid(rdValid),
        .rdReady(rdReady), .done(done), .excCode(excCode), .mapWr(mapWr),
        .mapAck(mapAck), .mapExc(mapExc), .odReq(odReq), .odRsp(odRsp),
        .userOut(userOut), .userIn(userIn));
    od_model odm (.sys_clk(sys_clk), .sys_rst(sys_rst), .odReq(odReq),
        .odRsp(odRsp), .lastIdx(lastIdx), .lastData(lastData));

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task final_report;
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic mw(input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] d, input logic [7:0] ex);
        mapWr = '{1'b1, idx, sub, d};
        @(negedge sys_clk);
        mapWr.valid = 1'b0;
        chk("mapAck", 32'(mapAck), 32'h1);
        chk("mapExc", 32'(mapExc), 32'(ex));
        @(negedge sys_clk);
    endtask : mw

    // one request: feeds write words, checks read words and result
    task automatic xfer(input logic [7:0] fc, input logic [15:0] ra,
        input logic [15:0] rq, input logic [15:0] wa, input logic [15:0] wq,
        input int wn, input int rn, input logic [7:0] ex);
        int wi = 0;
        int ri = 0;
        bit fin = 0;
        bit tk;
        req = '{1'b1, fc, ra, rq, wa, wq};
        wrValid = (wn > 0);
        wrWord = wbuf[0];
        rdReady = 1'b1;
        for (int n = 0; n < 400 && !fin; n++) begin
            #2;
            tk = (reqReady === 1'b1);
            if (rdValid === 1'b1 && ri < 8) begin
                chk("rdWord", 32'(rdWord), 32'(ebuf[ri]));
                ri++;
            end
            if (done === 1'b1) begin
                chk("excCode", 32'(excCode), 32'(ex));
                chk("read words", 32'(ri), 32'(rn));
                fin = 1;
            end
            if (wrValid && wrReady === 1'b1) wi++;
            @(negedge sys_clk);
            if (tk) req.valid = 1'b0;
            wrValid = (wi < wn);
            wrWord = wbuf[wi];
        end
        if (!fin) begin
            chk("done seen", 32'h0, 32'h1);
            final_report();
        end
        rdReady = 1'b0;
        @(negedge sys_clk);
    endtask : xfer

    task exc_cases;
        xfer(8'h05, BASE_TX, 16'h1, 0, 0, 0, 0, EXC_FUNC);
        xfer(FC_RD_HOLD, BASE_TX, 16'h0, 0, 0, 0, 0, EXC_VALUE);
        xfer(FC_RD_HOLD, BASE_TX, 16'h1, 0, 0, 0, 0, EXC_ADDR);
        xfer(FC_RD_HOLD, BASE_RX, 16'h1, 0, 0, 0, 0, EXC_ADDR);
        xfer(FC_RD_INPUT, BASE_UOUT + 16'h1, 16'h2, 0, 0, 0, 0, EXC_ADDR);
        xfer(FC_WR_MULTI, 0, 0, BASE_UIN, 16'h1, 0, 0, EXC_ADDR);
        xfer(FC_WR_SINGLE, 0, 0, BASE_UIN, 16'h1, 0, 0, EXC_FUNC);
        xfer(FC_WR_MULTI, 0, 0, BASE_UOUT, 16'h2, 0, 0, EXC_ADDR);
        xfer(FC_RD_HOLD, BASE_UIN, 16'h2, 0, 0, 0, 0, EXC_ADDR);
    endtask : exc_cases

    task tx_image;
        mw(IDX_TX_MAP, 8'h00, 32'h0, EXC_NONE);
        mw(IDX_TX_MAP, 8'h01, 32'h60410010, EXC_NONE);
        mw(IDX_TX_MAP, 8'h02, 32'h00050008, EXC_NONE);
        mw(IDX_TX_MAP, 8'h03, 32'h6061000c, EXC_VALUE);
        mw(IDX_TX_MAP, 8'h11, 32'h60610008, EXC_ADDR);
        mw(16'h3702, 8'h01, 32'h60610008, EXC_ADDR);
        mw(IDX_TX_MAP, 8'h03, 32'h60610008, EXC_NONE);
        mw(IDX_TX_MAP, 8'h00, 32'h11, EXC_VALUE);
        mw(IDX_TX_MAP, 8'h00, 32'h3, EXC_NONE);
        mw(IDX_TX_MAP, 8'h01, 32'h60410010, EXC_VALUE);
        ebuf[0] = 16'h6041;
        ebuf[1] = 16'h6100;
        xfer(FC_RD_HOLD, BASE_TX, 16'h2, 0, 0, 0, 2, EXC_NONE);
        xfer(FC_RD_INPUT, BASE_TX, 16'h2, 0, 0, 0, 2, EXC_NONE);
        xfer(FC_RD_HOLD, BASE_TX, 16'h3, 0, 0, 0, 0, EXC_ADDR);
        mw(IDX_TX_MAP, 8'h00, 32'h0, EXC_NONE);
        mw(IDX_TX_MAP, 8'h01, 32'hffff0010, EXC_NONE);
        mw(IDX_TX_MAP, 8'h00, 32'h1, EXC_NONE);
        xfer(FC_RD_HOLD, BASE_TX, 16'h1, 0, 0, 0, 0, EXC_FAIL);
    endtask : tx_image

    task rx_image;
        mw(IDX_RX_MAP, 8'h00, 32'h0, EXC_NONE);
        mw(IDX_RX_MAP, 8'h01, 32'h60400010, EXC_NONE);
        mw(IDX_RX_MAP, 8'h02, 32'h00030010, EXC_NONE);
        mw(IDX_RX_MAP, 8'h00, 32'h2, EXC_NONE);
        wbuf[0] = 16'h1234;
        xfer(FC_WR_SINGLE, 0, 0, BASE_RX, 16'h1, 1, 0, EXC_NONE);
        chk("object written", {lastIdx, lastData[15:0]}, 32'h60401234);
        wbuf[0] = 16'h5678;
        wbuf[1] = 16'h9abc;
        xfer(FC_WR_MULTI, 0, 0, BASE_RX, 16'h2, 2, 0, EXC_NONE);
        chk("object written", {lastIdx, lastData[15:0]}, 32'h60405678);
    endtask : rx_image

    task user_arrays;
        wbuf[0] = 16'habcd;
        wbuf[1] = 16'h0123;
        ebuf[0] = 16'h1111;
        ebuf[1] = 16'h2222;
        ebuf[2] = 16'h3333;
        ebuf[3] = 16'h4444;
        xfer(FC_RD_WR, BASE_UOUT, 16'h4, BASE_UIN, 16'h2, 2, 4, EXC_NONE);
        chk("userIn0", userIn[0], 32'habcd0123);
    endtask : user_arrays

    initial begin
        userOut[0] = 32'h11112222;
        userOut[1] = 32'h33334444;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk("reqReady", 32'(reqReady), 32'h1);
        chk("userIn0", userIn[0], 32'h0);
        exc_cases();
        tx_image();
        rx_image();
        user_arrays();
        final_report();
    end
endmodule : modbus_process_image_map_bench
`default_nettype wire
